// ### core/cief_defs.vh
// Purpose: Constants for the CAN interrupt enable and filter steering block.
// Assumes: AXI4-Lite register bus with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses.
`ifndef CIEF_DEFS_VH
`define CIEF_DEFS_VH
`define CIEF_OFF_IRQ_ENABLE   8'h00
`define CIEF_OFF_FILT_PTR     8'h04
`define CIEF_OFF_IRQ_STATUS   8'h08
`define CIEF_OFF_IRQ_MASK     8'h0C
`define CIEF_IE_RESET         16'h0000
`define CIEF_IE_IMPL_MASK     16'h00EF
`define CIEF_PTR_RESET        16'h0000
`define CIEF_BIT_TX_BUF       0
`define CIEF_BIT_RX_BUF       1
`define CIEF_BIT_RX_OVF       2
`define CIEF_BIT_FIFO_AF      3
`define CIEF_BIT_ERROR        5
`define CIEF_BIT_WAKEUP       6
`define CIEF_BIT_INVALID      7
`define CIEF_F4_LSB           0
`define CIEF_F5_LSB           4
`define CIEF_F6_LSB           8
`define CIEF_F7_LSB           12
`define CIEF_DEST_FIFO        4'hF
`define CIEF_STAT_RESET       8'h00
`define CIEF_MASK_RESET       8'hEF
`define CIEF_RESP_OKAY        2'b00
`define CIEF_RESP_SLVERR      2'b10
`endif

// ### core/cief_sync2.v
// Purpose: Two-flop synchroniser for one level from another domain.
// Assumes: Destination clock is clock, reset nrst active low.
// Notes:   Only the second flop is read outside.
`timescale 1ns/1ps
`default_nettype none
module cief_sync2 (
    // Clock and reset.
    input  wire clock,
    input  wire nrst,
    input  wire clk_en,
    // Level in and out.
    input  wire din,
    output reg  dout
);
    reg meta_q;

    // The first stage feeds only the second, to keep metastability contained.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else if (clk_en) begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // cief_sync2
`default_nettype wire

// ### core/cief_dest_sel.v
// Purpose: Steering decode for one acceptance filter.
// Assumes: Field value all ones means the receive FIFO.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "cief_defs.vh"
module cief_dest_sel (
    // Filter hit and its pointer field.
    input  wire       hit,
    input  wire [3:0] field,
    // Steering result.
    output wire       to_fifo,
    output wire       to_buf,
    output wire [3:0] buf_idx
);
    // All ones selects the FIFO; any other value names a buffer.
    assign to_fifo = hit && (field == `CIEF_DEST_FIFO);
    assign to_buf  = hit && (field != `CIEF_DEST_FIFO);
    assign buf_idx = field;
endmodule // cief_dest_sel
`default_nettype wire

// ### core/cief_top.v
// Purpose: CAN interrupt source enables and filter 4-7 receive steering.
// Assumes: 20 MHz clock, AXI4-Lite slave, event inputs from the CAN core.
// Notes:   Events from the CAN core share the clock; filter hits likewise.
//          The receive pin is the only asynchronous input and is synchronised.
//          The register map uses byte addresses on the 32-bit bus.
//          Offset 0x00 holds the enables in bits 7:5 and 3:0; bit 4 and 15:8 read zero.
//          Offset 0x04 holds four destination fields, filter 7 in the top nibble.
//          Offset 0x08 holds the sticky event flags, cleared by writing ones.
//          Offset 0x0C holds the source mask; a one lets that source through.
//          A destination field of 1111 steers to the receive FIFO; others name a buffer.
//          Several filters hitting together resolve to the lowest numbered one.
//          Only byte lanes 0 and 1 are stored; lanes 2 and 3 are ignored.
//          The mask resets open, so an enable and its flag alone raise the request.
//          All state holds while clk_en is low, and the bus readies drop with it.
// Function
// RULE1: Enables reset zero; clear bit blocks source.
// RULE2: Bit 7 enables invalid message interrupt.
// RULE3: Bit 6 enables bus wake-up interrupt.
// RULE4: Bit 5 enables error interrupt.
// RULE5: Bit 2 enables receive overflow interrupt.
// RULE6: Bits 3,1,0: FIFO, receive, transmit.
// RULE7: Four 4-bit pointers, filters 7..4, reset zero.
// RULE8: Filter hit stores per pointer; 1111 FIFO.
// RULE9: Request when flag and enable; unimplemented read zero.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cief_defs.vh"
module cief_top (
    // Clock, reset and enable.
    input  wire        clock,
    input  wire        nrst,
    input  wire        clk_en,
    // AXI4-Lite write address.
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [7:0]  s_axi_awaddr,
    // AXI4-Lite write data.
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response.
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address.
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [7:0]  s_axi_araddr,
    // AXI4-Lite read data.
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // Interrupt source events, one-cycle pulses, same clock.
    input  wire [7:0]  src_event,
    // Acceptance filter 4..7 hits, bit 0 is filter 4, same clock.
    input  wire [3:0]  filter_hit,
    // Controller interrupt request, level.
    output wire        irq,
    // Receive steering outcome, registered.
    output reg         store_valid,
    output reg         store_to_fifo,
    output reg  [3:0]  store_buf_idx,
    // Wake-up activity seen on the receive pin, asynchronous.
    input  wire        can_rx_pin
);
    // Register state, write staging and steering nets.
    reg  [15:0] irq_enable_q;
    reg  [15:0] filt_ptr_q;
    reg  [7:0]  irq_status_q;
    reg  [7:0]  irq_mask_q;
    reg  [7:0]  aw_addr_q;
    reg         aw_have_q;
    reg  [15:0] w_data_q;
    reg  [1:0]  w_strb_q;
    reg         w_have_q;
    reg         rx_prev_q;
    wire        rx_sync;
    wire        wake_evt;
    wire [7:0]  events;
    wire [7:0]  clr_bits;
    wire        do_write;
    wire [3:0]  hit_fifo;
    wire [15:0] hit_idx;
    wire [15:0] wmask;
    wire [7:0]  req_bits;
    wire [15:0] impl_mask;
    wire [3:0]  f4_field;
    wire [3:0]  f5_field;
    wire [3:0]  f6_field;
    wire [3:0]  f7_field;

    // The receive pin is asynchronous, so it is synchronised first.
    cief_sync2 u_rx_sync (
        .clock (clock),
        .nrst  (nrst),
        .clk_en(clk_en),
        .din   (can_rx_pin),
        .dout  (rx_sync)
    );

    // A falling edge on the idle-high pin counts as bus wake-up activity.
    // The previous level starts low: the synchroniser leaves reset low while the
    // pin rests high, and a high start here would fake an edge on the first cycle.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_prev_q <= 1'b0;
        end else if (clk_en) begin
            rx_prev_q <= rx_sync;
        end
    end
    assign wake_evt = rx_prev_q && !rx_sync;
    assign events = src_event | ({7'h00, wake_evt} << `CIEF_BIT_WAKEUP);

    // Write channels are taken independently and held until both are present.
    // The readies fall with clk_en, so no handshake completes while state is frozen.
    assign s_axi_awready = clk_en && !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = clk_en && !w_have_q && !s_axi_bvalid;
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 16'h0000;
            w_strb_q  <= 2'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                // Only the two low lanes reach any register, so only they are kept.
                w_data_q <= s_axi_wdata[15:0];
                w_strb_q <= s_axi_wstrb[1:0];
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Byte enables become a bit mask over the low sixteen bits.
    assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    // Implemented source positions, shared by the enables, mask and flags.
    assign impl_mask = `CIEF_IE_IMPL_MASK;
    assign clr_bits = (do_write && aw_addr_q == `CIEF_OFF_IRQ_STATUS && w_strb_q[0])
                      ? w_data_q[7:0] : 8'h00;

    // Register writes; unimplemented enable bits never store.
    // A write needs both channels; its response then stands until bready.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_enable_q <= `CIEF_IE_RESET; // see RULE1
            filt_ptr_q   <= `CIEF_PTR_RESET; // see RULE7
            irq_mask_q   <= `CIEF_MASK_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CIEF_RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `CIEF_RESP_OKAY;
                case (aw_addr_q)
                    `CIEF_OFF_IRQ_ENABLE: begin
                        irq_enable_q <= ((irq_enable_q & ~wmask) | (w_data_q[15:0] & wmask))
                                        & `CIEF_IE_IMPL_MASK; // see RULE9
                    end
                    `CIEF_OFF_FILT_PTR: begin
                        filt_ptr_q <= (filt_ptr_q & ~wmask) | (w_data_q[15:0] & wmask);
                    end
                    `CIEF_OFF_IRQ_STATUS: begin
                        // The flags themselves clear through clr_bits below.
                        s_axi_bresp <= `CIEF_RESP_OKAY;
                    end
                    `CIEF_OFF_IRQ_MASK: begin
                        if (w_strb_q[0]) begin
                            irq_mask_q <= w_data_q[7:0] & impl_mask[7:0];
                        end
                    end
                    default: begin
                        // Unmapped offsets answer with an error and change nothing.
                        s_axi_bresp <= `CIEF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Sticky event flags; an event in the clearing cycle keeps its flag set.
    // Bit 4 has no source, so the implemented mask keeps it clear.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_status_q <= `CIEF_STAT_RESET;
        end else if (clk_en) begin
            irq_status_q <= ((irq_status_q & ~clr_bits) | events) & impl_mask[7:0];
        end
    end

    // Each source reaches the request only through its enable and its mask.
    // The mask lets software silence a source for a while without touching its enable.
    assign req_bits = irq_status_q & irq_enable_q[7:0] & irq_mask_q; // see RULE1
    assign irq = (req_bits[`CIEF_BIT_INVALID]   // see RULE2
               | req_bits[`CIEF_BIT_WAKEUP]     // see RULE3
               | req_bits[`CIEF_BIT_ERROR]      // see RULE4
               | req_bits[`CIEF_BIT_RX_OVF]     // see RULE5
               | req_bits[`CIEF_BIT_FIFO_AF]    // see RULE6
               | req_bits[`CIEF_BIT_RX_BUF]
               | req_bits[`CIEF_BIT_TX_BUF]);   // see RULE9

    // Read channel: one read at a time, answered the cycle after it is taken.
    // Unmapped reads return zero with an error response.
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CIEF_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `CIEF_RESP_OKAY;
                case (s_axi_araddr)
                    `CIEF_OFF_IRQ_ENABLE: s_axi_rdata <= {16'h0000, irq_enable_q}; // see RULE9
                    `CIEF_OFF_FILT_PTR:   s_axi_rdata <= {16'h0000, filt_ptr_q};
                    `CIEF_OFF_IRQ_STATUS: s_axi_rdata <= {24'h000000, irq_status_q};
                    `CIEF_OFF_IRQ_MASK:   s_axi_rdata <= {24'h000000, irq_mask_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `CIEF_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Each filter's destination field, cut from the pointer register.
    assign f4_field = filt_ptr_q[`CIEF_F4_LSB +: 4]; // see RULE7
    assign f5_field = filt_ptr_q[`CIEF_F5_LSB +: 4];
    assign f6_field = filt_ptr_q[`CIEF_F6_LSB +: 4];
    assign f7_field = filt_ptr_q[`CIEF_F7_LSB +: 4];

    // One steering decoder per filter, each reading its own pointer field.
    cief_dest_sel u_f4 (
        .hit    (filter_hit[0]),
        .field  (f4_field),
        .to_fifo(hit_fifo[0]),
        .to_buf (),
        .buf_idx(hit_idx[3:0])
    );
    cief_dest_sel u_f5 (
        .hit    (filter_hit[1]),
        .field  (f5_field),
        .to_fifo(hit_fifo[1]),
        .to_buf (),
        .buf_idx(hit_idx[7:4])
    );
    cief_dest_sel u_f6 (
        .hit    (filter_hit[2]),
        .field  (f6_field),
        .to_fifo(hit_fifo[2]),
        .to_buf (),
        .buf_idx(hit_idx[11:8])
    );
    cief_dest_sel u_f7 (
        .hit    (filter_hit[3]),
        .field  (f7_field),
        .to_fifo(hit_fifo[3]),
        .to_buf (),
        .buf_idx(hit_idx[15:12])
    );

    // The lowest numbered filter wins when several hit at once.
    // store_valid is a one-cycle pulse; the destination holds until the next hit.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            store_valid   <= 1'b0;
            store_to_fifo <= 1'b0;
            store_buf_idx <= 4'h0;
        end else if (clk_en) begin
            store_valid <= |filter_hit; // see RULE8
            if (filter_hit[0]) begin
                store_to_fifo <= hit_fifo[0];
                store_buf_idx <= hit_idx[3:0];
            end else if (filter_hit[1]) begin
                store_to_fifo <= hit_fifo[1];
                store_buf_idx <= hit_idx[7:4];
            end else if (filter_hit[2]) begin
                store_to_fifo <= hit_fifo[2];
                store_buf_idx <= hit_idx[11:8];
            end else if (filter_hit[3]) begin
                store_to_fifo <= hit_fifo[3];
                store_buf_idx <= hit_idx[15:12];
            end
        end
    end
endmodule // cief_top
`default_nettype wire

// ### verif/cief_top_sva.sv
// Purpose: Port-level assertions for the CAN enable and steering block.
// Assumes: One clock domain, nrst active low; clk_en may drop for a while.
// Notes:   Bound into cief_top by name.
`timescale 1ns/1ps
`default_nettype none
`include "cief_defs.vh"
module cief_chk (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        clk_en,
    // Register bus.
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Request and steering.
    input wire logic [3:0]  filter_hit,
    input wire logic        irq,
    input wire logic        store_valid,
    input wire logic        store_to_fifo,
    input wire logic [3:0]  store_buf_idx
);
    // Every check shares the one clock and is silenced in reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    irq_reset_a: assert property ($rose(nrst) |-> !irq)
        else $error("irq high after reset");
    store_hit_a: assert property (clk_en && filter_hit != 4'h0 |=> store_valid)
        else $error("filter hit not stored");
    store_quiet_a: assert property (clk_en && filter_hit == 4'h0 |=> !store_valid)
        else $error("store without hit");
    store_dest_a: assert property (store_valid |-> store_to_fifo == (store_buf_idx == 4'hF))
        else $error("fifo flag disagrees with field");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    slverr_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == `CIEF_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    read_done_a: assert property (
        clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    write_done_a: assert property (
        clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule // cief_chk
bind cief_top cief_chk u_chk (.*);
`default_nettype wire

// ### verif/cief_can_node.sv
// Purpose: Other CAN nodes: wake-up activity on the pin and filter hits.
// Assumes: Bench raises one-cycle requests.
// Notes:   Idle bus is recessive, so the pin rests high.
`timescale 1ns/1ps
`default_nettype none
module cief_can_node (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Requests from the bench.
    input  wire logic       wake_req,
    input  wire logic [3:0] hit_req,
    // Bus side seen by the controller.
    output wire logic       can_rx_pin,
    output var  logic [3:0] filter_hit
);
    logic [2:0] dom_q;
    // A wake burst holds the bus dominant four clock cycles, long enough to sync.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dom_q      <= 3'h0;
            filter_hit <= 4'h0;
        end else begin
            dom_q      <= wake_req ? 3'h4 : dom_q - {2'h0, dom_q != 3'h0};
            filter_hit <= hit_req;
        end
    end
    assign can_rx_pin = (dom_q == 3'h0);
endmodule // cief_can_node
`default_nettype wire

// ### verif/test_can_irq_enable_filter_steering.sv
// Purpose: Self-checking bench for enables, interrupt and steering.
// Assumes: AXI4-Lite master tasks, 20 MHz clock.
// Notes:   Random pointers come from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none
`include "cief_defs.vh"
module test_can_irq_enable_filter_steering;
    logic        clock, nrst, clk_en, irq, can_rx_pin, wake_req, store_valid, store_to_fifo;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, src_event;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, rnd;
    logic [3:0]  s_axi_wstrb, filter_hit, store_buf_idx, hit_req, hv;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] ptr;
    int          fails, samples_checked, cyc;
    int          src[7] = '{0, 1, 2, 3, 5, 6, 7};
    cief_top DUT (.*);
    cief_can_node u_node (.*);
    // Free-running 50 ns clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 0;
        bit w = 0;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        rd_q = s_axi_rdata;
        rsp  = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One-cycle event; irq is settled when the task returns.
    task automatic pulse(input logic [7:0] ev);
        @(posedge clock);
        src_event <= ev;
        @(posedge clock);
        src_event <= 8'h00;
        @(posedge clock);
    endtask
    // The node adds a cycle before the hit reaches the controller.
    task automatic hit(input logic [3:0] h);
        @(posedge clock);
        hit_req <= h;
        @(posedge clock);
        hit_req <= 4'h0;
        repeat (2) @(posedge clock);
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Lowest filter among the hits decides the destination.
    function automatic logic [3:0] pick(input logic [15:0] p, input logic [3:0] h);
        for (int k = 3; k >= 0; k--) if (h[k]) pick = p[4 * k +: 4];
    endfunction
    // Hang guard.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {wake_req, src_event, hit_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        rnd = 32'hF14D284A;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i));
            // The mask resets open; every other register resets to zero.
            chk("reset", rd_q, (i == 3) ? 32'(`CIEF_MASK_RESET) : 32'h0);
        end
        wr(`CIEF_OFF_IRQ_ENABLE, 32'hFFFFFFFF);
        rd(`CIEF_OFF_IRQ_ENABLE);
        chk("enable bits", rd_q, 32'h000000EF);
        wr(8'h10, rnd);
        chk("unmapped bresp", rsp, `CIEF_RESP_SLVERR);
        rd(8'h10);
        chk("unmapped rresp", rsp, `CIEF_RESP_SLVERR);
        wr(`CIEF_OFF_IRQ_MASK, 32'hFF);
        // Each enable must pass its own source and no other.
        for (int i = 0; i < 7; i++) begin
            wr(`CIEF_OFF_IRQ_STATUS, 32'hFF);
            wr(`CIEF_OFF_IRQ_ENABLE, 32'h1 << src[i]);
            pulse(8'hFF ^ (8'h1 << src[i]));
            chk("other sources", irq, 1'b0);
            pulse(8'h1 << src[i]);
            chk("own source", irq, 1'b1);
            wr(`CIEF_OFF_IRQ_ENABLE, 32'h0);
            chk("disabled", irq, 1'b0);
        end
        wr(`CIEF_OFF_IRQ_ENABLE, 32'hEF);
        wr(`CIEF_OFF_IRQ_MASK, 32'h0);
        chk("masked", irq, 1'b0);
        wr(`CIEF_OFF_IRQ_MASK, 32'hFF);
        chk("unmasked", irq, 1'b1);
        wr(`CIEF_OFF_IRQ_STATUS, 32'hFF);
        chk("cleared", irq, 1'b0);
        // Wake-up activity arrives on the pin, not as an event.
        wr(`CIEF_OFF_IRQ_ENABLE, 32'h40);
        @(posedge clock);
        wake_req <= 1'b1;
        @(posedge clock);
        wake_req <= 1'b0;
        for (int n = 0; n < 12 && irq !== 1'b1; n++) @(posedge clock);
        chk("wake pin", irq, 1'b1);
        for (int r = 0; r < 6; r++) begin
            rnd = lfsr(rnd);
            ptr = (r == 0) ? 16'hF0F0 : rnd[15:0];
            wr(`CIEF_OFF_FILT_PTR, {rnd[31:16], ptr});
            rd(`CIEF_OFF_FILT_PTR);
            chk("pointer", rd_q, {16'h0, ptr});
            for (int k = 0; k < 5; k++) begin
                hv = (k < 4) ? 4'h1 << k : rnd[19:16] | 4'h8;
                hit(hv);
                chk("store valid", store_valid, 1'b1);
                chk("to fifo", store_to_fifo, pick(ptr, hv) == 4'hF);
                chk("buffer", store_buf_idx, pick(ptr, hv));
            end
        end
        // Only lane 0 is strobed, so the upper pointer byte must hold.
        s_axi_wstrb <= 4'h1;
        wr(`CIEF_OFF_FILT_PTR, 32'h0000A5A5);
        s_axi_wstrb <= 4'hF;
        rd(`CIEF_OFF_FILT_PTR);
        chk("byte lane", rd_q, {16'h0, ptr[15:8], 8'hA5});
        // A hit while the enable is low must leave the steering outputs frozen.
        clk_en <= 1'b0;
        hit(4'h1);
        chk("frozen store", store_valid, 1'b0);
        clk_en <= 1'b1;
        results();
    end
endmodule // test_can_irq_enable_filter_steering
`default_nettype wire
